/* File: common/nmt_slave_map.svh */
// Offsets, command codes, identifiers and timing counts of the management slave.
// Assumes inclusion by bare name from the package and the design module.
`ifndef NMT_SLAVE_MAP_SVH
`define NMT_SLAVE_MAP_SVH

`define ID_WIDTH          11
`define NODE_WIDTH        7
`define NMT_ID            11'h000
`define NMT_LEN           4'h2
`define CMD_OPERATIONAL   8'h01
`define CMD_STOP          8'h02
`define CMD_PREOP         8'h80
`define CMD_RESET_NODE    8'h81
`define CMD_RESET_COMM    8'h82
`define NODE_BROADCAST    8'h00
`define NODE_MIN          7'h01
`define ID_SYNC           11'h080
`define ID_EMCY_BASE      11'h080
`define ID_TPDO1_BASE     11'h180
`define ID_RPDO1_BASE     11'h200
`define ID_TPDO2_BASE     11'h280
`define ID_RPDO2_BASE     11'h300
`define ID_TPDO3_BASE     11'h380
`define ID_RPDO3_BASE     11'h400
`define ID_TPDO4_BASE     11'h480
`define ID_RPDO4_BASE     11'h500
`define ID_SDO_TX_BASE    11'h580
`define ID_SDO_RX_BASE    11'h600
`define ID_HEARTBEAT_BASE 11'h700
`define SAVE_KEY          32'h65766173
`define SAVE_DONE         32'h00000001
`define INIT_CYCLES       4'h4
`define MARKER_RESET      32'h00000000

`endif

/* File: common/nmt_slave_pkg.sv */
// Types shared by the management slave and its bench.
// Assumes the map header is on the include path.
`include "nmt_slave_map.svh"

package nmt_slave_pkg;

  typedef enum logic [1:0] {
    ST_INIT    = 2'b00,
    ST_PREOP   = 2'b01,
    ST_OPER    = 2'b11,
    ST_STOPPED = 2'b10
  } nmt_state_type;

endpackage : nmt_slave_pkg

/* File: logic/nmt_slave.sv */
// Management slave: command decode, state machine, service gating,
// default identifiers and configuration marker.
// Assumes frames arrive already received and checked, one cycle per frame,
// and object writes arrive as one-cycle strobes from the dictionary logic.
`timescale 1ns/100ps
`default_nettype none
`include "nmt_slave_map.svh"

module nmt_slave
  import nmt_slave_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [6:0]  node_id,
  input  wire logic        auto_start,
  input  wire logic        rx_valid,
  input  wire logic [10:0] rx_id,
  input  wire logic        rx_ext,
  input  wire logic        rx_rtr,
  input  wire logic [3:0]  rx_len,
  input  wire logic [7:0]  rx_byte0,
  input  wire logic [7:0]  rx_byte1,
  input  wire logic        obj_wr,
  input  wire logic        obj_savable,
  input  wire logic        obj_is_save_all,
  input  wire logic        obj_is_marker,
  input  wire logic        obj_marker_sub,
  input  wire logic [31:0] obj_data,
  input  wire logic        save_busy,
  input  wire logic        save_done,
  output logic             save_start,
  output logic [31:0]      save_all_value,
  output logic [31:0]      marker_date,
  output logic [31:0]      marker_time,
  output logic [1:0]       nmt_state,
  output logic             node_restart,
  output logic             comm_restart,
  output logic             pdo_enable,
  output logic             sdo_enable,
  output logic             sync_enable,
  output logic             emcy_enable,
  output logic             bootup_enable,
  output logic             nmt_enable,
  output logic             bootup_send,
  output logic             node_valid,
  output logic [10:0]      id_sync,
  output logic [10:0]      id_emcy,
  output logic [10:0]      id_sdo_rx,
  output logic [10:0]      id_sdo_tx,
  output logic [10:0]      id_tpdo1,
  output logic [10:0]      id_tpdo2,
  output logic [10:0]      id_tpdo3,
  output logic [10:0]      id_tpdo4,
  output logic [10:0]      id_rpdo1,
  output logic [10:0]      id_rpdo2,
  output logic [10:0]      id_rpdo3,
  output logic [10:0]      id_rpdo4,
  output logic [10:0]      id_heartbeat
);

  // ****************************************
  // Identifier arithmetic
  // ****************************************
  // Sum stays in 11 bits: top base 700, node below 80
  function automatic logic [10:0] node_ident(input logic [10:0] base,
                                             input logic [6:0]  node);
    node_ident = base + {4'h0, node};
  endfunction : node_ident

  // ****************************************
  // Registers
  // ****************************************
  nmt_state_type   state_reg;
  nmt_state_type   state_next;
  logic [3:0]      init_cnt_reg;
  logic [3:0]      init_cnt_next;
  logic            auto_pending_reg;
  logic [6:0]      node_reg;
  logic [6:0]      node_s1;
  logic [6:0]      node_s2;
  logic [31:0]     save_all_reg;
  logic [31:0]     date_reg;
  logic [31:0]     time_reg;
  logic            save_busy_s1;
  logic            save_busy_s2;
  logic            save_done_s1;
  logic            save_done_s2;
  logic            save_done_d;
  logic            save_start_reg;
  logic            node_restart_reg;
  logic            comm_restart_reg;
  logic            bootup_reg;

  // ****************************************
  // Command decode
  // ****************************************
  // standard-id two-byte frames only
  wire is_nmt_frame = rx_valid && !rx_ext && !rx_rtr &&
                      (rx_id == `NMT_ID) && (rx_len == `NMT_LEN);
  // node zero is never a valid own number
  wire node_ok      = (node_reg >= `NODE_MIN);
  // command byte zero, node byte one
  wire addressed    = (rx_byte1 == `NODE_BROADCAST) ||
                      (node_ok && (rx_byte1 == {1'b0, node_reg}));
  wire cmd_take     = is_nmt_frame && addressed && (state_reg != ST_INIT);
  wire cmd_oper     = cmd_take && (rx_byte0 == `CMD_OPERATIONAL);
  wire cmd_stop     = cmd_take && (rx_byte0 == `CMD_STOP);
  wire cmd_preop    = cmd_take && (rx_byte0 == `CMD_PREOP);
  wire cmd_rnode    = cmd_take && (rx_byte0 == `CMD_RESET_NODE);
  wire cmd_rcomm    = cmd_take && (rx_byte0 == `CMD_RESET_COMM);
  wire init_done    = (state_reg == ST_INIT) && (init_cnt_reg == `INIT_CYCLES);
  wire save_done_rise = save_done_s2 && !save_done_d;
  // save-all starts on the key only
  wire save_trig    = obj_wr && obj_is_save_all && (obj_data == `SAVE_KEY);
  // savable write except save-all and marker
  wire marker_clear = obj_wr && obj_savable && !obj_is_save_all && !obj_is_marker;

  // ****************************************
  // State machine
  // ****************************************
  always_comb begin
    state_next    = state_reg;
    init_cnt_next = 4'h0;
    case (state_reg)
      ST_INIT: begin
        init_cnt_next = init_cnt_reg + 4'h1;
        if (init_done) begin
          state_next    = ST_PREOP;
          init_cnt_next = 4'h0;
        end
      end
      ST_PREOP: begin
        if (auto_pending_reg && auto_start) begin
          state_next = ST_OPER;
        end
      end
      ST_OPER, ST_STOPPED: begin
        state_next = state_reg;
      end
      default: begin
        state_next = ST_INIT;
      end
    endcase
    // Commands override the automatic moves above
    // state change commands
    if (cmd_oper) begin
      state_next = ST_OPER;
    end else if (cmd_stop) begin
      state_next = ST_STOPPED;
    end else if (cmd_preop) begin
      state_next = ST_PREOP;
    end else if (cmd_rnode || cmd_rcomm) begin
      state_next    = ST_INIT;
      init_cnt_next = 4'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg    <= ST_INIT;
      init_cnt_reg <= 4'h0;
    end else begin
      state_reg    <= state_next;
      init_cnt_reg <= init_cnt_next;
    end
  end

  // Auto start only applies once per initialization pass
  // Cancelled by any accepted command
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      auto_pending_reg <= 1'b0;
    end else if (init_done) begin
      auto_pending_reg <= 1'b1;
    end else if (state_reg != ST_PREOP || cmd_take) begin
      auto_pending_reg <= 1'b0;
    end
  end

  // Switch inputs are asynchronous; two flops first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      node_s1 <= 7'h00;
      node_s2 <= 7'h00;
    end else begin
      node_s1 <= node_id;
      node_s2 <= node_s1;
    end
  end

  // Node number latched at each initialization, not live
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      node_reg <= 7'h00;
    end else if (state_reg == ST_INIT) begin
      node_reg <= node_s2;
    end
  end

  // ****************************************
  // Restart pulses and boot-up
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      node_restart_reg <= 1'b0;
      comm_restart_reg <= 1'b0;
      bootup_reg       <= 1'b0;
    end else begin
      node_restart_reg <= cmd_rnode;
      comm_restart_reg <= cmd_rcomm;
      // Boot-up pulse falls in first pre-operational cycle
      // boot-up sent on leaving initialization
      bootup_reg       <= init_done && node_ok;
    end
  end

  // ****************************************
  // Configuration marker and save trigger
  // ****************************************
  // Save status comes from slow storage logic; synchronised
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      save_busy_s1 <= 1'b0;
      save_busy_s2 <= 1'b0;
      save_done_s1 <= 1'b0;
      save_done_s2 <= 1'b0;
      save_done_d  <= 1'b0;
    end else begin
      save_busy_s1 <= save_busy;
      save_busy_s2 <= save_busy_s1;
      save_done_s1 <= save_done;
      save_done_s2 <= save_done_s1;
      save_done_d  <= save_done_s2;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      save_all_reg   <= `MARKER_RESET;
      save_start_reg <= 1'b0;
    end else begin
      // Refuse a second save while storage is busy
      // A key written while busy is kept but starts nothing
      save_start_reg <= save_trig && !save_busy_s2;
      if (save_done_rise) begin
        save_all_reg <= `SAVE_DONE;
      end else if (obj_wr && obj_is_save_all) begin
        save_all_reg <= obj_data;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      date_reg <= `MARKER_RESET;
      time_reg <= `MARKER_RESET;
    end else if (marker_clear) begin
      date_reg <= `MARKER_RESET;
      time_reg <= `MARKER_RESET;
    end else if (obj_wr && obj_is_marker) begin
      if (obj_marker_sub) begin
        time_reg <= obj_data;
      end else begin
        date_reg <= obj_data;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // service gating by state
  assign pdo_enable     = (state_reg == ST_OPER);
  assign sdo_enable     = (state_reg == ST_PREOP) || (state_reg == ST_OPER);
  assign sync_enable    = sdo_enable;
  assign emcy_enable    = sdo_enable;
  assign bootup_enable  = (state_reg == ST_INIT);
  assign nmt_enable     = (state_reg != ST_INIT);
  assign nmt_state      = state_reg;
  assign node_valid     = node_ok;
  // Pulses: one restart per accepted reset command
  assign node_restart   = node_restart_reg;
  assign comm_restart   = comm_restart_reg;
  assign bootup_send    = bootup_reg;
  assign save_start     = save_start_reg;
  assign save_all_value = save_all_reg;
  // marker words go out with the save image
  assign marker_date    = date_reg;
  assign marker_time    = time_reg;

  // ****************************************
  // Default identifiers
  // ****************************************
  // sync, emergency, service data, process data, heartbeat
  assign id_sync      = `ID_SYNC;
  assign id_emcy      = node_ident(`ID_EMCY_BASE, node_reg);
  assign id_sdo_rx    = node_ident(`ID_SDO_RX_BASE, node_reg);
  assign id_sdo_tx    = node_ident(`ID_SDO_TX_BASE, node_reg);
  assign id_tpdo1     = node_ident(`ID_TPDO1_BASE, node_reg);
  assign id_tpdo2     = node_ident(`ID_TPDO2_BASE, node_reg);
  assign id_tpdo3     = node_ident(`ID_TPDO3_BASE, node_reg);
  assign id_tpdo4     = node_ident(`ID_TPDO4_BASE, node_reg);
  assign id_rpdo1     = node_ident(`ID_RPDO1_BASE, node_reg);
  assign id_rpdo2     = node_ident(`ID_RPDO2_BASE, node_reg);
  assign id_rpdo3     = node_ident(`ID_RPDO3_BASE, node_reg);
  assign id_rpdo4     = node_ident(`ID_RPDO4_BASE, node_reg);
  assign id_heartbeat = node_ident(`ID_HEARTBEAT_BASE, node_reg);

endmodule : nmt_slave
`default_nettype wire

/* File: verif/nmt_slave_monitor.sv */
// Assertions on the ports of the management slave.
// Assumes a bind onto nmt_slave and a node number held steady.
`timescale 1ns/100ps
`default_nettype none
module nmt_slave_monitor (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [6:0]  node_id,
  input wire logic        rx_valid,
  input wire logic [10:0] rx_id,
  input wire logic        rx_ext,
  input wire logic        rx_rtr,
  input wire logic [3:0]  rx_len,
  input wire logic [7:0]  rx_byte0,
  input wire logic [7:0]  rx_byte1,
  input wire logic        obj_wr,
  input wire logic        obj_savable,
  input wire logic        obj_is_save_all,
  input wire logic        obj_is_marker,
  input wire logic [31:0] obj_data,
  input wire logic        save_busy,
  input wire logic        save_done,
  input wire logic        save_start,
  input wire logic [31:0] save_all_value,
  input wire logic [31:0] marker_date,
  input wire logic [1:0]  nmt_state,
  input wire logic        node_restart,
  input wire logic        comm_restart,
  input wire logic        bootup_send,
  input wire logic        pdo_enable,
  input wire logic        sdo_enable,
  input wire logic [10:0] id_sdo_rx,
  input wire logic [10:0] id_tpdo1,
  input wire logic [10:0] id_heartbeat
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Frame taken as a management command
  wire hit = rx_valid && !rx_ext && !rx_rtr && rx_id == 11'h000 && rx_len == 4'h2
    && nmt_state != 2'b00 && (rx_byte1 == 8'h00 || rx_byte1 == {1'b0, node_id});
  property p_op; hit && rx_byte0 == 8'h01 |=> nmt_state == 2'b11; endproperty
  a_op: assert property (p_op) else $error("start command missed");
  property p_stop; hit && rx_byte0 == 8'h02 |=> nmt_state == 2'b10; endproperty
  a_stop: assert property (p_stop) else $error("stop command missed");
  property p_node; hit && rx_byte0 == 8'h81 |=> node_restart && nmt_state == 2'b00; endproperty
  a_node: assert property (p_node) else $error("node restart missed");
  property p_comm; hit && rx_byte0 == 8'h82 |=> comm_restart && nmt_state == 2'b00; endproperty
  a_comm: assert property (p_comm) else $error("comm restart missed");
  property p_upsend; $past(nmt_state) == 2'b00 && nmt_state == 2'b01 && node_id != 7'h00
    |-> bootup_send; endproperty
  a_upsend: assert property (p_upsend) else $error("boot-up not sent");
  property p_busy; save_busy[*3] ##0 obj_wr && obj_is_save_all |=> !save_start; endproperty
  a_busy: assert property (p_busy) else $error("save started while busy");
  property p_init; $changed(nmt_state) && nmt_state == 2'b00 |-> node_restart || comm_restart;
  endproperty
  a_init: assert property (p_init) else $error("init entered without cause");
  property p_boot; nmt_state == 2'b00 |-> ##[1:8] nmt_state == 2'b01; endproperty
  a_boot: assert property (p_boot) else $error("init did not end");
  property p_gate; pdo_enable == (nmt_state == 2'b11) && sdo_enable == nmt_state[0]; endproperty
  a_gate: assert property (p_gate) else $error("service gating wrong");
  property p_ids; nmt_state != 2'b00 |-> id_sdo_rx == 11'h600 + node_id
    && id_tpdo1 == 11'h180 + node_id && id_heartbeat == 11'h700 + node_id; endproperty
  a_ids: assert property (p_ids) else $error("default identifier wrong");
  property p_mark; obj_wr && obj_savable && !obj_is_save_all && !obj_is_marker
    |=> marker_date == 32'h0; endproperty
  a_mark: assert property (p_mark) else $error("marker not cleared");
  property p_save; (!save_busy)[*3] ##0 obj_wr && obj_is_save_all
    && obj_data == 32'h65766173 |=> save_start; endproperty
  a_save: assert property (p_save) else $error("save not started");
  property p_done; $rose(save_done) |-> ##[2:6] save_all_value == 32'h1; endproperty
  a_done: assert property (p_done) else $error("save completion not shown");
  c_op: cover property (hit && rx_byte0 == 8'h01);
  c_comm: cover property (comm_restart);
  c_save: cover property (save_start);
endmodule : nmt_slave_monitor
`default_nettype wire

/* File: verif/store_model.sv */
// Behavioural non-volatile store answering save requests.
// Assumes save_start is a one-cycle pulse on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module store_model #(parameter int DLY = 3) (
  input wire logic ref_clk,
  input wire logic save_start,
  output logic     save_busy,
  output logic     save_done
);
  initial begin
    save_busy = 1'b0;
    save_done = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (save_start) begin
        save_busy <= 1'b1;
        save_done <= 1'b0;
        // Slow on purpose, to stress the wait
        repeat (DLY) @(posedge ref_clk);
        save_busy <= 1'b0;
        save_done <= 1'b1;
      end
    end
  end
endmodule : store_model
`default_nettype wire

/* File: verif/fieldbus_nmt_slave_dispatch_tb.sv */
// Random and directed bench for the management slave.
// Assumes store_model stands in for storage; monitor bound below.
`timescale 1ns/100ps
`default_nettype none
module fieldbus_nmt_slave_dispatch_tb;
  logic ref_clk = 0, rst = 1, auto_start = 0, rx_valid = 0, rx_ext = 0, rx_rtr = 0;
  logic obj_wr = 0, obj_savable = 0, obj_is_save_all = 0, obj_is_marker = 0;
  logic obj_marker_sub = 0, save_busy, save_done, save_start, node_restart, comm_restart;
  logic pdo_enable, sdo_enable, sync_enable, emcy_enable, bootup_enable, nmt_enable;
  logic bootup_send, node_valid;
  logic [6:0] node_id = 0;
  logic [3:0] rx_len = 2;
  logic [7:0] rx_byte0 = 0, rx_byte1 = 0, c, b;
  logic [1:0] nmt_state, e;
  logic [31:0] obj_data = 0, save_all_value, marker_date, marker_time;
  logic [10:0] rx_id = 0, id_sync, id_emcy, id_sdo_rx, id_sdo_tx, id_heartbeat;
  logic [10:0] id_tpdo1, id_tpdo2, id_tpdo3, id_tpdo4, id_rpdo1, id_rpdo2, id_rpdo3, id_rpdo4;
  logic [7:0] tbl [8] = '{8'h01, 8'h02, 8'h80, 8'h81, 8'h82, 8'h80, 8'h7f, 8'h01};
  int seed, r, i, mismatches = 0, comparisons = 0, cyc = 0;
  nmt_slave dut (.*);
  store_model #(.DLY(20)) store (.ref_clk(ref_clk), .save_start(save_start),
    .save_busy(save_busy), .save_done(save_done));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task print_verdict;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task send(input logic [7:0] cb, nb, input logic x, input logic [3:0] l);
    @(negedge ref_clk);
    rx_byte0 = cb;
    rx_byte1 = nb;
    rx_ext = x;
    rx_len = l;
    rx_valid = 1;
    @(negedge ref_clk);
    rx_valid = 0;
  endtask : send
  task wr(input logic sa, mk, sb, input logic [31:0] d);
    @(negedge ref_clk);
    {obj_is_save_all, obj_is_marker, obj_marker_sub, obj_data} = {sa, mk, sb, d};
    {obj_wr, obj_savable} = 2'b11;
    @(negedge ref_clk);
    obj_wr = 0;
  endtask : wr
  task wait_st(input logic [1:0] s);
    for (i = 0; i < 16 && nmt_state !== s; i++) @(negedge ref_clk);
  endtask : wait_st
  function logic [1:0] nx(input logic [1:0] s, input logic [7:0] cb);
    case (cb)
      8'h01: return 2'b11;
      8'h02: return 2'b10;
      8'h80: return 2'b01;
      8'h81, 8'h82: return 2'b00;
      default: return s;
    endcase
  endfunction : nx
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      print_verdict;
    end
  end
  initial begin
    seed = 99;
    r = $random(seed);
    node_id = {1'b1, r[5:0]};
    repeat (10) @(negedge ref_clk);
    rst = 0;
    chk({bootup_enable, nmt_enable, pdo_enable}, 3'b100);
    wait_st(2'b01);
    chk(nmt_state, 2'b01);
    chk(id_sdo_tx, 11'h580 + node_id);
    chk(id_rpdo4, 11'h500 + node_id);
    chk(id_heartbeat, 11'h700 + node_id);
    chk({id_sync, id_emcy}, {11'h080, 11'h080 + node_id});
    chk({id_sdo_rx, id_tpdo1}, {11'h600 + node_id, 11'h180 + node_id});
    chk({id_tpdo2, id_tpdo3}, {11'h280 + node_id, 11'h380 + node_id});
    chk({id_tpdo4, id_rpdo1}, {11'h480 + node_id, 11'h200 + node_id});
    chk({id_rpdo2, id_rpdo3}, {11'h300 + node_id, 11'h400 + node_id});
    chk(node_valid, 1'b1);
    $display("test identifiers done");
    e = 2'b01;
    repeat (60) begin
      r = $random(seed);
      c = tbl[r[2:0]];
      b = r[4:3] == 1 ? {1'b0, node_id} : r[4:3] == 2 ? {1'b0, node_id ^ 7'h01} : 8'h00;
      rx_id = {10'h000, r[9] & r[10]};
      rx_rtr = r[11] & r[12];
      send(c, b, r[5] & r[6], (r[7] & r[8]) ? 4'h3 : 4'h2);
      if (!rx_ext && !rx_rtr && rx_id == 11'h000 && rx_len == 4'h2 &&
          b != {1'b0, node_id ^ 7'h01}) e = nx(e, c);
      if (e == 2'b00) begin
        wait_st(2'b01);
        e = 2'b01;
      end
      chk(nmt_state, e);
      chk({pdo_enable, sdo_enable, sync_enable, emcy_enable, bootup_enable, nmt_enable},
          {e == 2'b11, e[0], e[0], e[0], 1'b0, 1'b1});
    end
    $display("test commands done");
    wr(0, 1, 0, 32'h20240611);
    wr(0, 1, 1, 32'h00093000);
    chk(marker_time, 32'h00093000);
    wr(0, 0, 0, r);
    chk(marker_date, 32'h0);
    chk(marker_time, 32'h0);
    wr(0, 1, 0, 32'h20240611);
    wr(1, 0, 0, 32'h65766173);
    chk(save_all_value, 32'h65766173);
    chk(save_start, 1'b1);
    repeat (3) @(negedge ref_clk);
    wr(1, 0, 0, 32'h65766173);
    chk(save_start, 1'b0);
    for (i = 0; i < 40 && save_all_value !== 32'h1; i++) @(negedge ref_clk);
    chk(save_all_value, 32'h1);
    chk(marker_date, 32'h20240611);
    $display("test marker done");
    rx_id = 11'h000;
    rx_rtr = 1'b0;
    auto_start = 1;
    send(8'h82, 8'h00, 1'b0, 4'h2);
    wait_st(2'b11);
    chk(nmt_state, 2'b11);
    chk(marker_date, 32'h20240611);
    $display("test auto start done");
    print_verdict;
  end
endmodule : fieldbus_nmt_slave_dispatch_tb
bind nmt_slave nmt_slave_monitor mon (.*);
`default_nettype wire
